//--- pkg/scbs_pkg.sv
// Package with control byte layout, reset values and timing constants
package scbs_pkg;
  // Control byte bit positions
  localparam int BIT_OUT_A = 7;
  localparam int BIT_OUT_B_REF = 6;
  localparam int BIT_OUT_C = 5;
  localparam int BIT_MAIN_FLOAT = 4;
  localparam int BIT_SEC_FLOAT = 3;
  localparam int BIT_OSC_STBY = 2;
  localparam int BIT_MAIN_STBY = 1;
  localparam int BIT_SEC_STBY = 0;
  localparam int CTRL_WIDTH = 8;
  // Power-up value: both loops in standby, everything else clear
  localparam logic [7:0] CTRL_RESET = 8'h03;
  // Output A function select code for general-purpose output
  localparam logic [1:0] OUTA_GPO = 2'h0;
  // Start-up assist time in microseconds and clock period in ns
  localparam int KICK_TIME_US = 4000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int KICK_CYCLES = (KICK_TIME_US * 1000) / CLK_PERIOD_NS;

  // Wake-up sequence of one loop
  typedef enum logic [1:0] {SCBS_ST_STANDBY, SCBS_ST_ARMED, SCBS_ST_RUN} scbs_wake_t;

  // Controls handed to one loop
  typedef struct packed {
    logic standby;
    logic float_req;
  } scbs_loop_ctrl_t;

  // Status returned by one loop
  typedef struct packed {
    logic counters_en;
    logic load_feedback;
    logic detector_reset;
    logic pulses_en;
    logic detector_float;
    logic locked;
  } scbs_loop_stat_t;
endpackage

//--- hdl/scbs_shift_in.sv
// Serial receiver that loads the control byte after eight bits
`timescale 1ns/1ps
`default_nettype none
module scbs_shift_in (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_enable_n_in,
  output logic byte_valid_out,
  output logic [7:0] byte_out
);
  logic [2:0] sync_clk_q, sync_dat_q, sync_en_q;
  logic [2:0] sync_clk_d, sync_dat_d, sync_en_d;
  logic [7:0] shift_q, shift_d, byte_q, byte_d;
  logic [3:0] count_q, count_d;
  logic valid_q, valid_d;
  logic rise, en_rise;

  // Two flops per pin, third stage only for edge detection
  always_comb begin
    sync_clk_d = {sync_clk_q[1:0], ser_clk_in};
    sync_dat_d = {sync_dat_q[1:0], ser_data_in};
    sync_en_d = {sync_en_q[1:0], ser_enable_n_in};
    rise = sync_clk_q[1] & ~sync_clk_q[2];
    en_rise = sync_en_q[1] & ~sync_en_q[2];
    shift_d = shift_q;
    count_d = count_q;
    byte_d = byte_q;
    valid_d = 1'b0;
    if (sync_en_q[1]) begin
      count_d = 4'h0;
    end else if (rise) begin
      shift_d = {shift_q[6:0], sync_dat_q[1]};
      if (count_q != 4'hf) begin
        count_d = count_q + 4'h1;
      end
    end
    // Byte takes effect only when exactly eight bits framed (see RULE24)
    if (en_rise && count_q == 4'h8) begin
      byte_d = shift_q;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync_clk_q <= 3'h0;
      sync_dat_q <= 3'h0;
      sync_en_q <= 3'h7;
      shift_q <= 8'h00;
      count_q <= 4'h0;
      byte_q <= scbs_pkg::CTRL_RESET;
      valid_q <= 1'b0;
    end else begin
      sync_clk_q <= sync_clk_d;
      sync_dat_q <= sync_dat_d;
      sync_en_q <= sync_en_d;
      shift_q <= shift_d;
      count_q <= count_d;
      byte_q <= byte_d;
      valid_q <= valid_d;
    end
  end

  assign byte_out = byte_q;
  assign byte_valid_out = valid_q;

  AST_BYTE_FRAMED: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    valid_q |-> $past(count_q) == 4'h8) // see RULE24
    else $error("Byte loaded without eight bits");
endmodule
`default_nettype wire

//--- hdl/scbs_loop_ctrl.sv
// Standby, float, wake-up and lock-hold control for one loop
`timescale 1ns/1ps
`default_nettype none
module scbs_loop_ctrl (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire scbs_pkg::scbs_loop_ctrl_t ctrl_in,
  input wire logic ref_pulse_in,
  input wire logic fb_pulse_in,
  input wire logic corr_pulse_in,
  input wire logic phase_in_window_in,
  output scbs_pkg::scbs_loop_stat_t stat_out
);
  scbs_pkg::scbs_wake_t st_q, st_d;
  logic float_q, float_d, lock_q, lock_d, load_q, load_d;

  always_comb begin
    st_d = st_q;
    float_d = float_q;
    lock_d = lock_q;
    load_d = 1'b0;
    case (st_q)
      scbs_pkg::SCBS_ST_STANDBY: begin
        lock_d = 1'b0;
        if (!ctrl_in.standby) begin
          st_d = scbs_pkg::SCBS_ST_ARMED; // counters on, pulses blocked (see RULE18)
        end
      end
      scbs_pkg::SCBS_ST_ARMED: begin
        if (ctrl_in.standby) begin
          st_d = scbs_pkg::SCBS_ST_STANDBY;
        end else if (ref_pulse_in) begin
          load_d = 1'b1; // load feedback counter, reset detector (see RULE19)
          st_d = scbs_pkg::SCBS_ST_RUN;
        end
      end
      default: begin
        if (ctrl_in.standby) begin
          st_d = scbs_pkg::SCBS_ST_STANDBY;
        end else if (ref_pulse_in || fb_pulse_in) begin
          lock_d = phase_in_window_in; // lock tracks window, floated or not (see RULE9)
        end
      end
    endcase
    // Float change waits until no correction pulse is active (see RULE7)
    if (!corr_pulse_in) begin
      float_d = ctrl_in.float_req; // lock flag untouched (see RULE8) (see RULE10)
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= scbs_pkg::SCBS_ST_STANDBY;
      float_q <= 1'b0;
      lock_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      st_q <= st_d;
      float_q <= float_d;
      lock_q <= lock_d;
      load_q <= load_d;
    end
  end

  // Standby floats detector and stops counters (see RULE17) (see RULE20)
  always_comb begin
    stat_out.counters_en = (st_q != scbs_pkg::SCBS_ST_STANDBY);
    stat_out.load_feedback = load_q;
    stat_out.detector_reset = load_q || (st_q == scbs_pkg::SCBS_ST_ARMED);
    stat_out.pulses_en = (st_q == scbs_pkg::SCBS_ST_RUN) && !load_q;
    stat_out.detector_float = float_q || (st_q != scbs_pkg::SCBS_ST_RUN); // see RULE6
    stat_out.locked = lock_q;
  end

  AST_FLOAT_HOLD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    corr_pulse_in |=> $stable(float_q)) // see RULE7
    else $error("Float changed during correction pulse");
  AST_WAKE_LOAD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (st_q == scbs_pkg::SCBS_ST_ARMED && !ctrl_in.standby && ref_pulse_in)
    |=> load_q && st_q == scbs_pkg::SCBS_ST_RUN) // see RULE19
    else $error("Wake-up load missed reference pulse");
  AST_ARMED_BLOCK: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    st_q == scbs_pkg::SCBS_ST_ARMED |-> !stat_out.pulses_en && stat_out.counters_en) // see RULE18
    else $error("Pulses passed while armed");
  AST_LOCK_KEEP: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ($rose(float_q) && !ctrl_in.standby) |-> lock_q == $past(lock_q)) // see RULE8
    else $error("Lock changed on float");
  AST_LOCK_DROP: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (st_q == scbs_pkg::SCBS_ST_RUN && !ctrl_in.standby && ref_pulse_in && !phase_in_window_in)
    |=> !lock_q) // see RULE9
    else $error("Lock held outside window");
  COV_WAKE: cover property (@(posedge ref_clk_in) disable iff (reset_in) load_q);
endmodule
`default_nettype wire

//--- hdl/scbs_top.sv
// Control byte register of the dual-loop synthesizer with its standby logic
//
// Summary of operation
// RULE1 - Output A general-purpose mode drives bit 7 level onto the pin.
// RULE2 - Other output A functions ignore bit 7.
// RULE3 - Config pin low: output B follows bit 6, floats while main standby.
// RULE4 - Config pin high: bit 6 picks crystal or external reference.
// RULE5 - Output C floats when bit 5 set, driven low otherwise.
// RULE6 - Float bits float a detector while its counters keep running.
// RULE7 - Float changes wait until the current correction pulse ends.
// RULE8 - A locked loop still reports lock right after floating.
// RULE9 - Floating loop drops lock once phase leaves the window.
// RULE10 - An unlocked loop stays unlocked when floated.
// RULE11 - Bit 2 shuts down reference oscillator; clear keeps it running.
// RULE12 - Reference shut down runs keep-alive unless the multiplier is off.
// RULE13 - Crystal mode: bit 2 falling starts a few-millisecond kick-start.
// RULE14 - Host sets oscillator standby only with both loop standby bits.
// RULE15 - Multiplier off when its three bits zero; host waits for pump-up.
// RULE16 - During pump-up host keeps loops in standby or detectors floated.
// RULE17 - Bit 1 stops the main loop and floats its detector.
// RULE18 - Main wake first enables counters with detector pulses blocked.
// RULE19 - Next reference pulse loads feedback, resets detector, then unblocks.
// RULE20 - Bit 0 stops the secondary loop and floats its detector.
// RULE21 - Config low: prescaler and aux outputs stop only on oscillator standby.
// RULE22 - Secondary loop wakes in the same two steps.
// RULE23 - Standby keeps registers and accepts writes of any bits together.
// RULE24 - Control byte loads as one eight-bit transfer, effective when complete.
`timescale 1ns/1ps
`default_nettype none
module scbs_top (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_enable_n_in,
  input wire logic mode_pin_in,
  input wire logic [1:0] output_a_select_in,
  input wire logic [2:0] multiplier_config_in,
  input wire logic out_a_alt_in,
  input wire logic main_reference_pulse_in,
  input wire logic main_feedback_pulse_in,
  input wire logic main_corr_pulse_in,
  input wire logic main_in_window_in,
  input wire logic secondary_reference_pulse_in,
  input wire logic secondary_feedback_pulse_in,
  input wire logic secondary_corr_pulse_in,
  input wire logic secondary_in_window_in,
  output logic output_a_out,
  output logic output_b_out,
  output logic output_b_oe_out,
  output logic output_c_out,
  output logic output_c_oe_out,
  output logic external_ref_sel_out,
  output logic osc_enable_out,
  output logic keep_alive_en_out,
  output logic kick_start_out,
  output logic multiplier_en_out,
  output logic aux_prescaler_en_out,
  output scbs_pkg::scbs_loop_stat_t main_stat_out,
  output scbs_pkg::scbs_loop_stat_t secondary_stat_out,
  output logic [7:0] control_byte_out
);
  logic byte_valid;
  logic [7:0] rx_byte;
  logic [7:0] ctrl_q, ctrl_d;
  logic [2:0] mode_sync_q, mode_sync_d;
  logic mode_hi, osc_stby;
  logic [21:0] kick_cnt_q, kick_cnt_d;
  logic main_ref_s, main_fb_s, main_corr_s, main_win_s;
  logic sec_ref_s, sec_fb_s, sec_corr_s, sec_win_s;
  logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [7:0] pin_raw;
  scbs_pkg::scbs_loop_ctrl_t main_ctrl, sec_ctrl;

  // Serial port receiver
  scbs_shift_in u_rx (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .ser_clk_in(ser_clk_in),
    .ser_data_in(ser_data_in),
    .ser_enable_n_in(ser_enable_n_in),
    .byte_valid_out(byte_valid),
    .byte_out(rx_byte)
  );

  // Whole byte replaces register at once, in any standby state (see RULE24) (see RULE23)
  always_comb begin
    ctrl_d = ctrl_q;
    if (byte_valid) begin
      ctrl_d = rx_byte;
    end
  end

  // Loop-side pulse inputs come from the analog domain; synchronise them
  assign pin_raw = {main_reference_pulse_in, main_feedback_pulse_in, main_corr_pulse_in,
                    main_in_window_in, secondary_reference_pulse_in,
                    secondary_feedback_pulse_in, secondary_corr_pulse_in,
                    secondary_in_window_in};

  // Mode pin synchroniser, level taken from second stage, third stage unused
  always_comb begin
    mode_sync_d = {mode_sync_q[1:0], mode_pin_in};
  end
  assign mode_hi = mode_sync_q[1];

  // Reference and feedback edges from second to third stage, correction and window levels from second stage
  assign main_ref_s = pin_s2_q[7] & ~pin_s3_q[7];
  assign main_fb_s = pin_s2_q[6] & ~pin_s3_q[6];
  assign main_corr_s = pin_s2_q[5];
  assign main_win_s = pin_s2_q[4];
  assign sec_ref_s = pin_s2_q[3] & ~pin_s3_q[3];
  assign sec_fb_s = pin_s2_q[2] & ~pin_s3_q[2];
  assign sec_corr_s = pin_s2_q[1];
  assign sec_win_s = pin_s2_q[0];

  assign osc_stby = ctrl_q[scbs_pkg::BIT_OSC_STBY];

  // Kick-start timer on oscillator standby release in crystal mode
  // Release is tested first: standby is still set in the cycle the new byte lands
  always_comb begin
    kick_cnt_d = kick_cnt_q;
    if (byte_valid && ctrl_q[scbs_pkg::BIT_OSC_STBY]
        && !rx_byte[scbs_pkg::BIT_OSC_STBY] && !external_ref_sel_out) begin
      kick_cnt_d = 22'(scbs_pkg::KICK_CYCLES); // see RULE13
    end else if (osc_stby || external_ref_sel_out) begin
      kick_cnt_d = 22'h0;
    end else if (kick_cnt_q != 22'h0) begin
      kick_cnt_d = kick_cnt_q - 22'h1;
    end
  end

  // Registers: control byte, pin synchronisers and kick timer
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_q <= scbs_pkg::CTRL_RESET;
      mode_sync_q <= 3'h0;
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      pin_s3_q <= 8'h00;
      kick_cnt_q <= 22'h0;
    end else begin
      ctrl_q <= ctrl_d;
      mode_sync_q <= mode_sync_d;
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      kick_cnt_q <= kick_cnt_d;
    end
  end

  // Loop control bundles
  always_comb begin
    main_ctrl.standby = ctrl_q[scbs_pkg::BIT_MAIN_STBY];
    main_ctrl.float_req = ctrl_q[scbs_pkg::BIT_MAIN_FLOAT];
    sec_ctrl.standby = ctrl_q[scbs_pkg::BIT_SEC_STBY];
    sec_ctrl.float_req = ctrl_q[scbs_pkg::BIT_SEC_FLOAT];
  end

  // Main loop sequencer (see RULE17) (see RULE18) (see RULE19)
  scbs_loop_ctrl u_main (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .ctrl_in(main_ctrl),
    .ref_pulse_in(main_ref_s),
    .fb_pulse_in(main_fb_s),
    .corr_pulse_in(main_corr_s),
    .phase_in_window_in(main_win_s),
    .stat_out(main_stat_out)
  );

  // Secondary loop sequencer (see RULE20) (see RULE22)
  scbs_loop_ctrl u_sec (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .ctrl_in(sec_ctrl),
    .ref_pulse_in(sec_ref_s),
    .fb_pulse_in(sec_fb_s),
    .corr_pulse_in(sec_corr_s),
    .phase_in_window_in(sec_win_s),
    .stat_out(secondary_stat_out)
  );

  // General-purpose outputs
  always_comb begin
    if (output_a_select_in == scbs_pkg::OUTA_GPO) begin
      output_a_out = ctrl_q[scbs_pkg::BIT_OUT_A]; // see RULE1
    end else begin
      output_a_out = out_a_alt_in; // bit 7 ignored (see RULE2)
    end
    output_b_out = ctrl_q[scbs_pkg::BIT_OUT_B_REF];
    output_b_oe_out = !mode_hi && !ctrl_q[scbs_pkg::BIT_MAIN_STBY]; // see RULE3
    output_c_out = 1'b0;
    output_c_oe_out = !ctrl_q[scbs_pkg::BIT_OUT_C]; // see RULE5
    external_ref_sel_out = mode_hi && ctrl_q[scbs_pkg::BIT_OUT_B_REF]; // see RULE4
  end

  // Reference, keep-alive, multiplier and auxiliary output enables
  always_comb begin
    osc_enable_out = !osc_stby; // see RULE11
    multiplier_en_out = (multiplier_config_in != 3'h0); // see RULE15
    keep_alive_en_out = osc_stby && multiplier_en_out; // see RULE12
    kick_start_out = (kick_cnt_q != 22'h0);
    if (mode_hi) begin
      aux_prescaler_en_out = !ctrl_q[scbs_pkg::BIT_SEC_STBY] && !osc_stby;
    end else begin
      aux_prescaler_en_out = !osc_stby; // see RULE21
    end
  end

  assign control_byte_out = ctrl_q;

  AST_OUTA_GPO: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (output_a_select_in == scbs_pkg::OUTA_GPO) |-> output_a_out == ctrl_q[7]) // see RULE1
    else $error("Output A not following bit 7");
  AST_OUTB: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ctrl_q[1] |-> !output_b_oe_out) // see RULE3
    else $error("Output B driven in main standby");
  AST_OUTC: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    output_c_oe_out == !ctrl_q[5] && !output_c_out) // see RULE5
    else $error("Output C wrong");
  AST_REFSEL: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !mode_hi |-> !external_ref_sel_out) // see RULE4
    else $error("External reference in crystal-only mode");
  AST_KICK: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (byte_valid && ctrl_q[2] && !rx_byte[2] && !external_ref_sel_out) |=> ##1 kick_start_out) // see RULE13
    else $error("Kick-start not engaged");
  AST_KEEPALIVE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    keep_alive_en_out == (osc_stby && multiplier_config_in != 3'h0)) // see RULE12
    else $error("Keep-alive wrong");
  AST_BYTE_LOAD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    byte_valid |=> ctrl_q == $past(rx_byte)) // see RULE24
    else $error("Control byte not loaded");
  AST_MAIN_FLOAT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ctrl_q[1] |=> main_stat_out.detector_float) // see RULE17
    else $error("Main detector not floating in standby");

  // Secondary loop standby floats its detector
  AST_SEC_FLOAT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ctrl_q[0] |=> secondary_stat_out.detector_float) // see RULE20
    else $error("Secondary detector not floating in standby");

  // Output A passes the alternate signal when not a plain output
  AST_OUTA_ALT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (output_a_select_in != scbs_pkg::OUTA_GPO) |-> output_a_out == out_a_alt_in) // see RULE2
    else $error("Output A not on alternate function");

  // Output B level and drive enable
  AST_OUTB_LEVEL: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    output_b_oe_out |-> output_b_out == ctrl_q[6]) // see RULE3
    else $error("Output B level wrong");
  AST_OUTB_DRIVE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (!mode_hi && !ctrl_q[1]) |-> output_b_oe_out) // see RULE3
    else $error("Output B not driven while main loop active");

  // Reference select follows bit 6 with the config pin high
  AST_REFSEL_HI: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    mode_hi |-> external_ref_sel_out == ctrl_q[6]) // see RULE4
    else $error("Reference select not following bit 6");

  // Oscillator enable is the inverse of its standby bit
  AST_OSC_EN: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    osc_enable_out == !ctrl_q[2]) // see RULE11
    else $error("Oscillator enable wrong");

  // Multiplier off takes keep-alive with it
  AST_MULT_OFF: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (multiplier_config_in == 3'h0) |-> !multiplier_en_out && !keep_alive_en_out) // see RULE15
    else $error("Multiplier or keep-alive on with config zero");

  // Auxiliary prescaler stops on oscillator standby, runs otherwise in low mode
  AST_AUX_LOW_MODE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (!mode_hi && !ctrl_q[2]) |-> aux_prescaler_en_out) // see RULE21
    else $error("Prescaler stopped without oscillator standby");
  AST_AUX_OSC: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ctrl_q[2] |-> !aux_prescaler_en_out) // see RULE21
    else $error("Prescaler running in oscillator standby");

  // No kick-start with an external reference or during oscillator standby
  AST_KICK_EXT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    external_ref_sel_out |=> !kick_start_out) // see RULE13
    else $error("Kick-start with external reference");
  AST_KICK_OSC: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (osc_stby && !byte_valid) |=> !kick_start_out) // see RULE13
    else $error("Kick-start during oscillator standby");
  COV_BYTE: cover property (@(posedge ref_clk_in) disable iff (reset_in) byte_valid);
  COV_KICK: cover property (@(posedge ref_clk_in) disable iff (reset_in) $rose(kick_start_out));
  COV_FLOAT: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    $rose(main_stat_out.detector_float) && main_stat_out.locked);
endmodule
`default_nettype wire

//--- verif/scbs_host_model.sv
// Host model that writes control bytes over the serial pins
`timescale 1ns/1ps
`default_nettype none
module scbs_host_model (
  input wire logic ref_clk_in,
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic ser_enable_n_out
);
  // Serial clock idles low between frames
  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    ser_enable_n_out = 1'b1;
  end

  // Send the top bits of a byte, MSB first, five ref clocks low and four high per bit
  task automatic send_frame(input logic [7:0] b, input int bits);
    logic [7:0] v;
    v = b;
    if (v[2]) v[1:0] = 2'b11; // Osc standby only with both loops down
    @(posedge ref_clk_in);
    ser_enable_n_out <= 1'b0;
    for (int i = 7; i > 7 - bits; i--) begin
      @(posedge ref_clk_in);
      ser_data_out <= v[i];
      repeat (4) @(posedge ref_clk_in);
      ser_clk_out <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      ser_clk_out <= 1'b0;
    end
    repeat (4) @(posedge ref_clk_in);
    ser_enable_n_out <= 1'b1;
    ser_data_out <= ~ser_data_out; // Released line must not hold the last bit
  endtask
endmodule
`default_nettype wire

//--- verif/synth_control_byte_standby_test.sv
// Self-checking bench for the control byte and standby logic
`timescale 1ns/1ps
`default_nettype none
module synth_control_byte_standby_test;
  logic ref_clk_in, reset_in, ser_clk, ser_data, ser_en_n, mode_q, alt_q;
  logic [1:0] sel_q, ref_p, fb_p, corr_q, win_q, lf_seen, s;
  logic [2:0] mult_q, mult_prev, mc;
  logic out_a, out_b, out_b_oe, out_c, out_c_oe, ext_sel, osc_en, keep, kick, mult_en, aux_en;
  logic m, a;
  scbs_pkg::scbs_loop_stat_t main_st, sec_st;
  logic [7:0] ctrl, b;
  int fail_count, checks, seed, n;

  // Free-running reference clock
  initial ref_clk_in = 1'b0;
  always #25 ref_clk_in = ~ref_clk_in;

  scbs_host_model u_host (.ref_clk_in(ref_clk_in), .ser_clk_out(ser_clk),
    .ser_data_out(ser_data), .ser_enable_n_out(ser_en_n));

  scbs_top u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .ser_clk_in(ser_clk),
    .ser_data_in(ser_data), .ser_enable_n_in(ser_en_n), .mode_pin_in(mode_q),
    .output_a_select_in(sel_q), .multiplier_config_in(mult_q), .out_a_alt_in(alt_q),
    .main_reference_pulse_in(ref_p[1]), .main_feedback_pulse_in(fb_p[1]),
    .main_corr_pulse_in(corr_q[1]), .main_in_window_in(win_q[1]),
    .secondary_reference_pulse_in(ref_p[0]), .secondary_feedback_pulse_in(fb_p[0]),
    .secondary_corr_pulse_in(corr_q[0]), .secondary_in_window_in(win_q[0]),
    .output_a_out(out_a), .output_b_out(out_b), .output_b_oe_out(out_b_oe),
    .output_c_out(out_c), .output_c_oe_out(out_c_oe), .external_ref_sel_out(ext_sel),
    .osc_enable_out(osc_en), .keep_alive_en_out(keep), .kick_start_out(kick),
    .multiplier_en_out(mult_en), .aux_prescaler_en_out(aux_en),
    .main_stat_out(main_st), .secondary_stat_out(sec_st), .control_byte_out(ctrl));

  // Expected pin levels from byte, mode pin, output A select, alt and multiplier bits
  function automatic logic [8:0] expect_pins(input logic [7:0] v, input logic md,
      input logic [1:0] sl, input logic al, input logic [2:0] mcf);
    expect_pins = {(sl == scbs_pkg::OUTA_GPO) ? v[7] : al, ~md & ~v[1], ~md & ~v[1] & v[6],
      ~v[5], md & v[6], ~v[2], v[2] & (|mcf), |mcf, ~v[2] & ~(md & v[0])};
  endfunction

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask

  // Verdict and end of run
  task automatic conclude;
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One frame, then time for the byte to land
  task automatic wr(input logic [7:0] v, input int bits);
    u_host.send_frame(v, bits);
    repeat (8) @(posedge ref_clk_in);
    #1;
  endtask

  // Reference and feedback pulses, noting any feedback load
  task automatic pulse(input logic [1:0] r, input logic [1:0] f);
    @(posedge ref_clk_in);
    ref_p <= r;
    fb_p <= f;
    lf_seen = 2'b00;
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk_in);
      if (i == 3) begin
        ref_p <= 2'b00;
        fb_p <= 2'b00;
      end
      #1;
      lf_seen |= {main_st.load_feedback === 1'b1, sec_st.load_feedback === 1'b1};
    end
  endtask

  // Main sequence
  initial begin
    seed = 72913;
    fail_count = 0;
    checks = 0;
    reset_in = 1'b1;
    {mode_q, alt_q, sel_q, ref_p, fb_p, corr_q, win_q} = '0;
    mult_q = 3'h1;
    mult_prev = 3'h1;
    repeat (12) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    check(ctrl, scbs_pkg::CTRL_RESET);
    check({out_b_oe, out_c_oe, out_c, ext_sel, main_st.locked, kick}, 6'h10);
    // Random bytes with random select, alt and multiplier pins; mode pin high for the first eight
    for (int i = 0; i < 16; i++) begin
      b = 8'($random(seed));
      m = (i < 8);
      s = 2'($random(seed));
      a = 1'($random(seed));
      mc = (i == 3) ? 3'h0 : 3'($random(seed));
      if (i >= 7) b[2] = 1'b0;
      if (m) b[6] = 1'b1;
      if (b[2]) b[1:0] = 2'b11;
      if (mult_prev == 3'h0 && mc != 3'h0) b[4:3] = 2'b11;
      mult_prev = mc;
      @(posedge ref_clk_in);
      mode_q <= m;
      sel_q <= s;
      alt_q <= a;
      mult_q <= mc;
      wr(b, 8);
      check(ctrl, b);
      check({out_a, out_b_oe & ~m, out_b & out_b_oe & ~m, out_c_oe, ext_sel, osc_en, keep, mult_en, aux_en}, expect_pins(b, m, s, a, mc));
      check({main_st.counters_en, sec_st.counters_en, main_st.detector_float | ~b[1], sec_st.detector_float | ~b[0], kick, out_c}, {~b[1], ~b[0], 4'b1100});
    end
    wr(8'h5a, 7);
    check(ctrl, b);
    // Two-step wake of both loops
    wr(8'h03, 8);
    wr(8'h00, 8);
    check({main_st.counters_en, main_st.pulses_en, main_st.detector_reset, sec_st.counters_en, sec_st.pulses_en, sec_st.detector_reset}, 6'h2d);
    @(posedge ref_clk_in);
    win_q <= 2'b11;
    pulse(2'b11, 2'b00);
    check({lf_seen, main_st.pulses_en, sec_st.pulses_en}, 4'hf);
    pulse(2'b11, 2'b11);
    check({main_st.locked, sec_st.locked}, 2'b11);
    // Float held off during a correction pulse, lock kept
    @(posedge ref_clk_in);
    corr_q <= 2'b11;
    wr(8'h18, 8);
    check({main_st.detector_float, sec_st.detector_float}, 2'b00);
    @(posedge ref_clk_in);
    corr_q <= 2'b00;
    repeat (3) @(posedge ref_clk_in);
    #1;
    check({main_st.detector_float, sec_st.detector_float, main_st.locked, sec_st.locked, main_st.counters_en, sec_st.counters_en}, 6'h3f);
    @(posedge ref_clk_in);
    win_q <= 2'b00;
    pulse(2'b11, 2'b11);
    check({main_st.locked, sec_st.locked}, 2'b00);
    wr(8'h00, 8);
    check({main_st.detector_float, sec_st.detector_float}, 2'b00);
    wr(8'h18, 8);
    check({main_st.locked, sec_st.locked, main_st.detector_float, sec_st.detector_float}, 4'h3);
    // Oscillator standby and kick-start length in crystal mode
    wr(8'h07, 8);
    check({osc_en, kick}, 2'b00);
    u_host.send_frame(8'h03, 8);
    for (int k = 0; k < 40 && kick !== 1'b1; k++) begin
      @(posedge ref_clk_in);
      #1;
    end
    n = 0;
    while (kick === 1'b1 && n < 90000) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    check(16'(n >= scbs_pkg::KICK_CYCLES - 2 && n <= scbs_pkg::KICK_CYCLES + 2), 16'h1);
    check(osc_en, 1'b1);
    conclude();
  end

  // Watchdog against a hang
  initial begin
    repeat (98000) @(posedge ref_clk_in);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
